// >>> logic/pwrc_pkg.sv
/*
 * constants and carrier types of the power control and auto-wakeup register block.
 * assumes a 32-bit axi4-lite register bus and one system clock.
 */
package pwrc_pkg;

   // ******************************************************************
   // register map
   // ******************************************************************
   localparam logic [31:0] PWRC_ADDR_POWER_CONTROL    = 32'h4000_7000;
   localparam logic [31:0] PWRC_ADDR_POWER_STATUS     = 32'h4000_7004;
   localparam logic [31:0] PWRC_ADDR_AUTOWAKE_CTL_STS = 32'h4000_7008;
   localparam logic [31:0] PWRC_ADDR_AUTOWAKE_WINDOW  = 32'h4000_700c;
   localparam logic [31:0] PWRC_ADDR_AUTOWAKE_PRESC   = 32'h4000_7010;

   // ******************************************************************
   // field positions and reset values
   // ******************************************************************
   localparam int          PWRC_THRESH_LSB        = 5;
   localparam int          PWRC_THRESH_MSB        = 7;
   localparam int          PWRC_MON_EN_BIT        = 4;
   localparam int          PWRC_STBY_SEL_BIT      = 1;
   localparam int          PWRC_BELOW_FLAG_BIT    = 2;
   localparam int          PWRC_AWU_EN_BIT        = 1;
   localparam int          PWRC_WIN_W             = 6;
   localparam int          PWRC_PSC_W             = 4;
   localparam int          PWRC_DIV_W             = 14;
   localparam logic [2:0]  PWRC_THRESH_RST        = 3'h0;
   localparam logic [5:0]  PWRC_WINDOW_RST        = 6'h3f;
   localparam logic [3:0]  PWRC_PSC_RST           = 4'h0;
   localparam logic [3:0]  PWRC_PSC_OFF           = 4'h0;
   localparam logic [3:0]  PWRC_PSC_TOP_A         = 4'he;
   localparam logic [3:0]  PWRC_PSC_TOP_B         = 4'hf;
   localparam logic [13:0] PWRC_DIV_TOP           = 14'h2800;
   localparam logic [13:0] PWRC_DIV_ONE           = 14'h0001;
   localparam logic [3:0]  PWRC_PSC_SHIFT_BIAS    = 4'h1;

   // ******************************************************************
   // bus answers
   // ******************************************************************
   localparam logic [1:0]  PWRC_RESP_OKAY         = 2'h0;
   localparam logic [1:0]  PWRC_RESP_DECERR       = 2'h3;

   // ******************************************************************
   // types
   // ******************************************************************
   typedef struct packed {
      logic [2:0] monitor_threshold_select;
      logic       supply_monitor_enable;
      logic       deep_sleep_standby_select;
   } pwrc_ctl_type;

   localparam pwrc_ctl_type PWRC_CTL_RST = '{PWRC_THRESH_RST, 1'b0, 1'b0};

   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  strb;
   } pwrc_wdata_type;

   typedef enum logic [2:0] {
      PWRC_RUN     = 3'h1,
      PWRC_SLEEP   = 3'h2,
      PWRC_STANDBY = 3'h4
   } pwrc_state_type;

endpackage

// >>> logic/pwrc_top.sv
/*
 * power control, supply monitor status and periodic auto-wakeup, with an axi4-lite slave.
 * assumes all inputs synchronous to i_mclk; i_lsi_tick is a one-cycle pulse per
 * low-speed oscillator period; the analog monitor and the interrupt unit lie outside.
 */
// Added by the designer: the AXI4-Lite slave port.
// How it works
// R1: threshold field bits 7:5 drives the monitor's eight-level threshold select.
// R2: monitor enable bit 4 switches the supply monitor on; reset off.
// R3: with deep sleep requested, select bit 1 picks standby, else sleep.
// R4: waking from standby returns power control fields to reset values.
// R5: status bit 2 shows supply below threshold, valid while monitor enabled.
// R6: power status contents are kept across a standby wake-up.
// R7: writing 1 to autowake bit 1 enables periodic wake; 0 never enables.
// R8: six-bit window compared with wakeup counter; equality raises a wake pulse.
// R9: window register resets to all ones in its six bits.
// R10: prescale code 0000 stops, 1000 divides by 128, 1110/1111 by 0x2800.
// R11: intermediate prescale codes divide by successive powers of two.
// R12: standby-reset option makes standby entry a system reset instead.
// R13: standby needs deep sleep, select bit and wait instruction; otherwise sleep.
// R14: monitor output drives interrupt line 8 on crossings in both directions.
// R15: reserved bits read zero and ignore writes.
`timescale 1ns/1ps
module pwrc_top (
   input  wire logic                  i_mclk,
   input  wire logic                  i_rst_n,
   input  wire logic [31:0]           i_awaddr,
   input  wire logic                  i_awvalid,
   output logic                       o_awready,
   input  wire logic [31:0]           i_wdata,
   input  wire logic [3:0]            i_wstrb,
   input  wire logic                  i_wvalid,
   output logic                       o_wready,
   output logic [1:0]                 o_bresp,
   output logic                       o_bvalid,
   input  wire logic                  i_bready,
   input  wire logic [31:0]           i_araddr,
   input  wire logic                  i_arvalid,
   output logic                       o_arready,
   output logic [31:0]                o_rdata,
   output logic [1:0]                 o_rresp,
   output logic                       o_rvalid,
   input  wire logic                  i_rready,
   input  wire logic                  i_supply_below,
   input  wire logic                  i_lsi_tick,
   input  wire logic                  i_core_deep_sleep_request,
   input  wire logic                  i_wait_instr,
   input  wire logic                  i_wake_event,
   input  wire logic                  i_standby_reset_option,
   output logic [2:0]                 o_monitor_threshold_select,
   output logic                       o_supply_monitor_enable,
   output logic                       o_external_interrupt_unit_line8,
   output logic                       o_sleep_active,
   output logic                       o_standby_active,
   output logic                       o_system_reset_req,
   output logic                       o_autowake_wakeup
);
   import pwrc_pkg::*;

   // ******************************************************************
   // state
   // ******************************************************************
   pwrc_ctl_type              ctl_q;
   logic                      below_q;
   logic                      awu_en_q;
   logic [PWRC_WIN_W-1:0]     window_q;
   logic [PWRC_PSC_W-1:0]     psc_q;
   logic [PWRC_DIV_W-1:0]     div_cnt_q;
   logic [PWRC_WIN_W-1:0]     awu_cnt_q;
   logic                      awu_hit_q;
   pwrc_state_type            state_q;
   pwrc_state_type            state_d;
   logic                      sys_rst_q;
   logic                      external_interrupt_unit_q;

   logic                      aw_full_q;
   logic [31:0]               aw_addr_q;
   logic                      w_full_q;
   pwrc_wdata_type            w_q;
   logic                      bvalid_q;
   logic [1:0]                bresp_q;
   logic                      rvalid_q;
   logic [31:0]               rdata_q;
   logic [1:0]                rresp_q;

   logic                      do_write;
   logic                      wr_lane0;
   logic                      standby_exit;
   logic [PWRC_DIV_W-1:0]     div_len;
   logic                      psc_tick;
   logic [31:0]               rd_val;
   logic                      rd_hit;

   // ******************************************************************
   // axi4-lite handshakes
   // ******************************************************************
   assign o_awready = !aw_full_q && !bvalid_q;
   assign o_wready  = !w_full_q && !bvalid_q;
   assign o_arready = !rvalid_q;
   assign do_write  = aw_full_q && w_full_q && !bvalid_q;
   assign wr_lane0  = do_write && w_q.strb[0];
   assign o_bvalid  = bvalid_q;
   assign o_bresp   = bresp_q;
   assign o_rvalid  = rvalid_q;
   assign o_rdata   = rdata_q;
   assign o_rresp   = rresp_q;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
      end else if (i_awvalid && o_awready) begin
         aw_full_q <= 1'b1;
         aw_addr_q <= i_awaddr;
      end else if (do_write) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         w_full_q <= 1'b0;
         w_q      <= '0;
      end else if (i_wvalid && o_wready) begin
         w_full_q <= 1'b1;
         w_q      <= '{i_wdata, i_wstrb};
      end else if (do_write) begin
         w_full_q <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bvalid_q <= 1'b0;
         bresp_q  <= PWRC_RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         case (aw_addr_q)
            PWRC_ADDR_POWER_CONTROL,
            PWRC_ADDR_POWER_STATUS,
            PWRC_ADDR_AUTOWAKE_CTL_STS,
            PWRC_ADDR_AUTOWAKE_WINDOW,
            PWRC_ADDR_AUTOWAKE_PRESC: bresp_q <= PWRC_RESP_OKAY;
            default:                  bresp_q <= PWRC_RESP_DECERR;
         endcase
      end else if (i_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ******************************************************************
   // read mux
   // ******************************************************************
   always_comb begin
      rd_val = 32'h0000_0000;                                    // [R15]
      rd_hit = 1'b1;
      case (i_araddr)
         PWRC_ADDR_POWER_CONTROL: begin
            rd_val[PWRC_THRESH_MSB:PWRC_THRESH_LSB] = ctl_q.monitor_threshold_select;
            rd_val[PWRC_MON_EN_BIT]   = ctl_q.supply_monitor_enable;
            rd_val[PWRC_STBY_SEL_BIT] = ctl_q.deep_sleep_standby_select;
         end
         PWRC_ADDR_POWER_STATUS:     rd_val[PWRC_BELOW_FLAG_BIT] = below_q;  // [R5]
         PWRC_ADDR_AUTOWAKE_CTL_STS: rd_val[PWRC_AWU_EN_BIT] = awu_en_q;
         PWRC_ADDR_AUTOWAKE_WINDOW:  rd_val[PWRC_WIN_W-1:0] = window_q;
         PWRC_ADDR_AUTOWAKE_PRESC:   rd_val[PWRC_PSC_W-1:0] = psc_q;
         default:                    rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= PWRC_RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_val;
         rresp_q  <= rd_hit ? PWRC_RESP_OKAY : PWRC_RESP_DECERR;
      end else if (i_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ******************************************************************
   // power control register
   // ******************************************************************
   assign standby_exit = (state_q == PWRC_STANDBY) && (i_wake_event || awu_hit_q);

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_q <= PWRC_CTL_RST;
      end else if (standby_exit) begin
         ctl_q <= PWRC_CTL_RST;                                  // [R4]
      end else if (wr_lane0 && aw_addr_q == PWRC_ADDR_POWER_CONTROL) begin
         ctl_q.monitor_threshold_select  <=
            w_q.data[PWRC_THRESH_MSB:PWRC_THRESH_LSB];           // [R1]
         ctl_q.supply_monitor_enable     <= w_q.data[PWRC_MON_EN_BIT];    // [R2]
         ctl_q.deep_sleep_standby_select <= w_q.data[PWRC_STBY_SEL_BIT];  // [R3]
      end
   end

   assign o_monitor_threshold_select = ctl_q.monitor_threshold_select;  // [R1]
   assign o_supply_monitor_enable    = ctl_q.supply_monitor_enable;     // [R2]

   // ******************************************************************
   // supply monitor flag and line 8 event
   // ******************************************************************
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         below_q <= 1'b0;
      end else if (ctl_q.supply_monitor_enable) begin
         below_q <= i_supply_below;                              // [R5] [R6]
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         external_interrupt_unit_q <= 1'b0;
      end else begin
         external_interrupt_unit_q <= ctl_q.supply_monitor_enable && (i_supply_below != below_q);  // [R14]
      end
   end

   assign o_external_interrupt_unit_line8 = external_interrupt_unit_q;

   // ******************************************************************
   // auto-wakeup registers
   // ******************************************************************
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         awu_en_q <= 1'b0;
      end else if (wr_lane0 && aw_addr_q == PWRC_ADDR_AUTOWAKE_CTL_STS) begin
         awu_en_q <= w_q.data[PWRC_AWU_EN_BIT];                  // [R7]
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         window_q <= PWRC_WINDOW_RST;                            // [R9]
      end else if (wr_lane0 && aw_addr_q == PWRC_ADDR_AUTOWAKE_WINDOW) begin
         window_q <= w_q.data[PWRC_WIN_W-1:0];                   // [R15]
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         psc_q <= PWRC_PSC_RST;
      end else if (wr_lane0 && aw_addr_q == PWRC_ADDR_AUTOWAKE_PRESC) begin
         psc_q <= w_q.data[PWRC_PSC_W-1:0];
      end
   end

   // ******************************************************************
   // prescaler and wakeup counter
   // ******************************************************************
   always_comb begin
      if (psc_q == PWRC_PSC_TOP_A || psc_q == PWRC_PSC_TOP_B) begin
         div_len = PWRC_DIV_TOP;                                 // [R10]
      end else begin
         div_len = PWRC_DIV_ONE << (psc_q - PWRC_PSC_SHIFT_BIAS); // [R11]
      end
   end

   assign psc_tick = awu_en_q && (psc_q != PWRC_PSC_OFF) && i_lsi_tick
                     && (div_cnt_q >= div_len - PWRC_DIV_ONE);   // [R10]

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_cnt_q <= '0;
      end else if (!awu_en_q || psc_q == PWRC_PSC_OFF || psc_tick) begin
         div_cnt_q <= '0;
      end else if (i_lsi_tick) begin
         div_cnt_q <= div_cnt_q + PWRC_DIV_ONE;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         awu_cnt_q <= '0;
         awu_hit_q <= 1'b0;
      end else begin
         awu_hit_q <= 1'b0;
         if (!awu_en_q) begin
            awu_cnt_q <= '0;
         end else if (psc_tick) begin
            if (awu_cnt_q == window_q) begin
               awu_cnt_q <= '0;
               awu_hit_q <= 1'b1;                                // [R8]
            end else begin
               awu_cnt_q <= awu_cnt_q + 6'h01;
            end
         end
      end
   end

   assign o_autowake_wakeup = awu_hit_q;

   // ******************************************************************
   // low-power mode sequencer
   // ******************************************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         PWRC_RUN: begin
            if (i_wait_instr) begin
               if (i_core_deep_sleep_request && ctl_q.deep_sleep_standby_select) begin
                  state_d = i_standby_reset_option ? PWRC_RUN : PWRC_STANDBY;  // [R13] [R12]
               end else begin
                  state_d = PWRC_SLEEP;                          // [R3] [R13]
               end
            end
         end
         PWRC_SLEEP: begin
            if (i_wake_event || awu_hit_q) begin
               state_d = PWRC_RUN;
            end
         end
         PWRC_STANDBY: begin
            if (standby_exit) begin
               state_d = PWRC_RUN;
            end
         end
         default: state_d = PWRC_RUN;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= PWRC_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sys_rst_q <= 1'b0;
      end else begin
         sys_rst_q <= (state_q == PWRC_RUN) && i_wait_instr && i_core_deep_sleep_request
                      && ctl_q.deep_sleep_standby_select && i_standby_reset_option;  // [R12]
      end
   end

   assign o_system_reset_req = sys_rst_q;
   assign o_sleep_active     = (state_q == PWRC_SLEEP);
   assign o_standby_active   = (state_q == PWRC_STANDBY);

endmodule

// >>> sim/pwrc_sva.sv
/*
 * port checker of the power control and auto-wakeup register block.
 * assumes it is bound onto pwrc_top and sees only its ports.
 */
`timescale 1ns/1ps
module pwrc_sva (
   input wire logic       i_mclk,
   input wire logic       i_rst_n,
   input wire logic       i_awvalid,
   input wire logic       o_awready,
   input wire logic       i_wvalid,
   input wire logic       o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic       o_bvalid,
   input wire logic       i_bready,
   input wire logic       i_arvalid,
   input wire logic       o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic       o_rvalid,
   input wire logic       i_rready,
   input wire logic       i_supply_below,
   input wire logic       i_wait_instr,
   input wire logic       i_standby_reset_option,
   input wire logic       o_supply_monitor_enable,
   input wire logic       o_external_interrupt_unit_line8,
   input wire logic       o_sleep_active,
   input wire logic       o_standby_active,
   input wire logic       o_system_reset_req
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   // ****************************************************
   // sequences and assertions
   // ****************************************************
   sequence s_wr_taken;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   sequence s_rd_taken;
      i_arvalid && o_arready;
   endsequence
   sequence s_mon_steady;
      $past(o_supply_monitor_enable) && $past(o_supply_monitor_enable, 2);
   endsequence

   a_write_answer: assert property (s_wr_taken |-> ##2 o_bvalid)
      else $error("write answer missing");
   a_read_answer: assert property (s_rd_taken |=> o_rvalid)
      else $error("read answer missing");
   a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write answer dropped");
   a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read answer dropped");
   a_write_stall: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken while answer pending");
   a_read_block: assert property (o_rvalid |-> !o_arready)
      else $error("read taken while answer pending");
   a_external_interrupt_unit_cross: assert property (
      s_mon_steady |-> o_external_interrupt_unit_line8 == ($past(i_supply_below) != $past(i_supply_below, 2)))
      else $error("line 8 pulse wrong");
   a_reset_req_cause: assert property (
      o_system_reset_req |-> $past(i_standby_reset_option)
         && ($past(i_wait_instr) || $past(i_wait_instr, 2)))
      else $error("system reset request without cause");
   a_mode_exclusive: assert property (!(o_sleep_active && o_standby_active))
      else $error("sleep and standby together");
endmodule

bind pwrc_top pwrc_sva u_sva (.i_mclk, .i_rst_n, .i_awvalid, .o_awready, .i_wvalid,
   .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid,
   .i_rready, .i_supply_below, .i_wait_instr, .i_standby_reset_option,
   .o_supply_monitor_enable, .o_external_interrupt_unit_line8, .o_sleep_active, .o_standby_active,
   .o_system_reset_req);

// >>> sim/tb_top.sv
/*
 * self-checking bench of the power control and auto-wakeup register block.
 * assumes pwrc_pkg and pwrc_top; drives the axi4-lite slave and side inputs.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import pwrc_pkg::*;
   logic i_mclk = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
   logic i_arvalid = 0, i_rready = 0, i_supply_below = 0, i_lsi_tick = 0;
   logic i_core_deep_sleep_request = 0, i_wait_instr = 0, i_wake_event = 0;
   logic i_standby_reset_option = 0;
   logic [31:0] i_awaddr = 0, i_wdata = 0, i_araddr = 0, o_rdata;
   logic [3:0]  i_wstrb = 4'hf;
   logic [2:0]  o_monitor_threshold_select;
   logic [1:0]  o_bresp, o_rresp;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_supply_monitor_enable;
   logic o_external_interrupt_unit_line8, o_sleep_active, o_standby_active, o_system_reset_req;
   logic o_autowake_wakeup;
   int bad_count = 0, tests_run = 0, cyc = 0, wk_n = 0, wk_t = 0, wk_gap = 0;
   int rr_n = 0, ex_n = 0;
   logic [31:0] lfsr = 32'h77d3cac1;
   logic [33:0] expq[$];
   logic [33:0] exp_v;

   pwrc_top DUT (.i_mclk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
      .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
      .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_supply_below, .i_lsi_tick,
      .i_core_deep_sleep_request, .i_wait_instr, .i_wake_event, .i_standby_reset_option,
      .o_monitor_threshold_select, .o_supply_monitor_enable, .o_external_interrupt_unit_line8,
      .o_sleep_active, .o_standby_active, .o_system_reset_req, .o_autowake_wakeup);

   always #12.5 i_mclk = ~i_mclk;
   always @(posedge i_mclk) cyc <= cyc + 1;

   // ****************************************************
   // output watchers
   // ****************************************************
   always @(negedge i_mclk) begin
      if (o_autowake_wakeup === 1'b1) begin
         wk_gap = cyc - wk_t;
         wk_t = cyc;
         wk_n++;
      end
      if (o_system_reset_req === 1'b1) rr_n++;
      if (o_external_interrupt_unit_line8 === 1'b1) ex_n++;
      if (o_rvalid === 1'b1 && i_rready) begin
         exp_v = (expq.size() > 0) ? expq.pop_front() : 34'h0;
         `CHK("read answer", exp_v, {o_rresp, o_rdata})
      end
   end

   // ****************************************************
   // helpers
   // ****************************************************
   function logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function logic [33:0] ok(input logic [31:0] v);
      return {PWRC_RESP_OKAY, v};
   endfunction
   function int div_len(input logic [3:0] c);
      return (c >= 4'he) ? 32'h2800 : (1 << (c - 1));
   endfunction

   task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ta, tw, tb;
      logic [1:0] br;
      @(posedge i_mclk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge i_mclk);
         ta = i_awvalid & o_awready;
         tw = i_wvalid & o_wready;
         tb = (o_bvalid === 1'b1);
         br = o_bresp;
         @(posedge i_mclk);
         if (ta) i_awvalid <= 1'b0;
         if (tw) i_wvalid <= 1'b0;
      end
      i_bready <= 1'b0;
      `CHK("write answer", r, br)
   endtask

   task rd(input logic [31:0] a, input logic [33:0] e);
      logic tr, tv;
      expq.push_back(e);
      @(posedge i_mclk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      tv = 1'b0;
      while (!tv) begin
         @(negedge i_mclk);
         tr = i_arvalid & o_arready;
         tv = (o_rvalid === 1'b1);
         @(posedge i_mclk);
         if (tr) i_arvalid <= 1'b0;
      end
      i_rready <= 1'b0;
   endtask

   task pulse_in(input logic wk);
      @(posedge i_mclk);
      if (wk) i_wake_event <= 1'b1; else i_wait_instr <= 1'b1;
      @(posedge i_mclk);
      i_wake_event <= 1'b0;
      i_wait_instr <= 1'b0;
      repeat (3) @(posedge i_mclk);
      @(negedge i_mclk);
   endtask

   task below(input logic v, input int n);
      @(posedge i_mclk);
      i_supply_below <= v;
      repeat (4) @(posedge i_mclk);
      `CHK("line 8 pulses", n, ex_n)
      rd(PWRC_ADDR_POWER_STATUS, ok({29'h0, v, 2'h0}));
   endtask

   task auto_wakeup_unit(input logic [3:0] c, input logic [5:0] w);
      int w0;
      wr(PWRC_ADDR_AUTOWAKE_PRESC, {28'h0, c}, PWRC_RESP_OKAY);
      wr(PWRC_ADDR_AUTOWAKE_WINDOW, {26'h0, w}, PWRC_RESP_OKAY);
      w0 = wk_n;
      wr(PWRC_ADDR_AUTOWAKE_CTL_STS, 32'h2, PWRC_RESP_OKAY);
      for (int i = 0; i < 3 * 32'h2800 && wk_n < w0 + 2; i++) @(posedge i_mclk);
      `CHK("wake period", (w + 1) * div_len(c), wk_gap)
      wr(PWRC_ADDR_AUTOWAKE_CTL_STS, 32'h0, PWRC_RESP_OKAY);
   endtask

   task end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge i_mclk);
      bad_count++;
      end_of_test();
   end

   // ****************************************************
   // main sequence
   // ****************************************************
   initial begin
      logic [31:0] d;
      logic [3:0] codes[6];
      codes = '{4'h2, 4'h5, 4'h8, 4'hd, 4'he, 4'hf};
      repeat (10) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      rd(PWRC_ADDR_POWER_CONTROL, ok(32'h0));
      rd(PWRC_ADDR_POWER_STATUS, ok(32'h0));
      rd(PWRC_ADDR_AUTOWAKE_CTL_STS, ok(32'h0));
      rd(PWRC_ADDR_AUTOWAKE_WINDOW, ok(32'h3f));
      rd(PWRC_ADDR_AUTOWAKE_PRESC, ok(32'h0));
      rd(32'h4000_7014, {PWRC_RESP_DECERR, 32'h0});
      wr(32'h4000_7014, rnd(), PWRC_RESP_DECERR);
      for (int t = 0; t < 8; t++) begin
         d = rnd();
         d[7:5] = t[2:0];
         wr(PWRC_ADDR_POWER_CONTROL, d, PWRC_RESP_OKAY);
         rd(PWRC_ADDR_POWER_CONTROL, ok({24'h0, d[7:4], 2'h0, d[1], 1'b0}));
         `CHK("threshold", t[2:0], o_monitor_threshold_select)
         `CHK("monitor enable", d[4], o_supply_monitor_enable)
      end
      wr(PWRC_ADDR_POWER_CONTROL, 32'h10, PWRC_RESP_OKAY);
      below(1'b1, 1);
      below(1'b0, 2);
      below(1'b1, 3);
      wr(PWRC_ADDR_POWER_CONTROL, 32'h12, PWRC_RESP_OKAY);
      pulse_in(1'b0);
      `CHK("sleep without deep", 2'b10, {o_sleep_active, o_standby_active})
      pulse_in(1'b1);
      `CHK("sleep exit", 1'b0, o_sleep_active)
      @(posedge i_mclk);
      i_core_deep_sleep_request <= 1'b1;
      wr(PWRC_ADDR_POWER_CONTROL, 32'h10, PWRC_RESP_OKAY);
      pulse_in(1'b0);
      `CHK("deep sleep select 0", 2'b10, {o_sleep_active, o_standby_active})
      pulse_in(1'b1);
      wr(PWRC_ADDR_POWER_CONTROL, 32'hf2, PWRC_RESP_OKAY);
      @(posedge i_mclk);
      i_standby_reset_option <= 1'b1;
      pulse_in(1'b0);
      `CHK("reset request", 1, rr_n)
      `CHK("no standby", 1'b0, o_standby_active)
      @(posedge i_mclk);
      i_standby_reset_option <= 1'b0;
      pulse_in(1'b0);
      `CHK("standby entry", 2'b01, {o_sleep_active, o_standby_active})
      pulse_in(1'b1);
      `CHK("standby exit", 1'b0, o_standby_active)
      rd(PWRC_ADDR_POWER_CONTROL, ok(32'h0));
      `CHK("threshold after exit", 3'h0, o_monitor_threshold_select)
      rd(PWRC_ADDR_POWER_STATUS, ok(32'h4));
      wr(PWRC_ADDR_AUTOWAKE_CTL_STS, 32'hffff_ffff, PWRC_RESP_OKAY);
      rd(PWRC_ADDR_AUTOWAKE_CTL_STS, ok(32'h2));
      wr(PWRC_ADDR_AUTOWAKE_CTL_STS, 32'h0, PWRC_RESP_OKAY);
      rd(PWRC_ADDR_AUTOWAKE_CTL_STS, ok(32'h0));
      d = rnd();
      wr(PWRC_ADDR_AUTOWAKE_WINDOW, d, PWRC_RESP_OKAY);
      rd(PWRC_ADDR_AUTOWAKE_WINDOW, ok({26'h0, d[5:0]}));
      i_wstrb <= 4'he;
      wr(PWRC_ADDR_AUTOWAKE_WINDOW, 32'h0, PWRC_RESP_OKAY);
      i_wstrb <= 4'hf;
      rd(PWRC_ADDR_AUTOWAKE_WINDOW, ok({26'h0, d[5:0]}));
      @(posedge i_mclk);
      i_lsi_tick <= 1'b1;
      wr(PWRC_ADDR_AUTOWAKE_PRESC, 32'h0, PWRC_RESP_OKAY);
      wr(PWRC_ADDR_AUTOWAKE_CTL_STS, 32'h2, PWRC_RESP_OKAY);
      d = wk_n;
      repeat (100) @(posedge i_mclk);
      `CHK("prescaler off", d, wk_n)
      wr(PWRC_ADDR_AUTOWAKE_CTL_STS, 32'h0, PWRC_RESP_OKAY);
      auto_wakeup_unit(4'h2, 6'h5);
      foreach (codes[i]) auto_wakeup_unit(codes[i], 6'h0);
      end_of_test();
   end
endmodule
